//--- dos_clk_gen.sv
// shared constants and types of the decoder sequencing block, and the clock
// range divider with its PLL setting decode.
// assumes one reference clock and a reset already synchronised by the top.

// ----------------------------------------------------------------------
// package
// ----------------------------------------------------------------------
package dos_pkg;
  localparam logic [4:0] OFS_MODE = 5'h00;
  localparam logic [4:0] OFS_STATUS = 5'h01;
  localparam logic [4:0] OFS_TONE = 5'h02;
  localparam logic [4:0] OFS_CLOCK_CONFIG = 5'h03;
  localparam logic [4:0] OFS_AUDIO_RATE = 5'h05;
  localparam logic [4:0] OFS_HEADER_DATA_0 = 5'h08;
  localparam logic [4:0] OFS_HEADER_DATA_1 = 5'h09;
  localparam logic [4:0] OFS_VOLUME = 5'h0B;
  localparam logic [4:0] OFS_PLAY_SPEED = 5'h10;
  localparam logic [4:0] OFS_BYTE_RATE = 5'h11;
  localparam logic [4:0] OFS_POSITION_LO = 5'h12;
  localparam logic [4:0] OFS_POSITION_HI = 5'h13;
  localparam logic [4:0] OFS_END_FILL = 5'h14;
  // mode register fields
  localparam int MODE_SOFT_RESET_BIT = 2;
  localparam int MODE_CANCEL_BIT = 3;
  localparam int MODE_CLOCK_RANGE_BIT = 15;
  // clock config fields
  localparam int PLL_MULT_MSB = 15;
  localparam int PLL_MULT_LSB = 13;
  // status register fields
  localparam int STAT_NO_JUMP_BIT = 0;
  localparam int STAT_ANALOG_PD_BIT = 1;
  localparam int STAT_PLL_ON_BIT = 2;
  localparam int STAT_DECODING_BIT = 3;
  localparam int STAT_DATA_REQUEST_BIT = 4;
  // reset values and codes
  localparam logic [15:0] MODE_RESET = 16'h0000;
  localparam logic [15:0] CLOCK_CONFIG_RESET = 16'h0000;
  localparam logic [15:0] VOLUME_RESET = 16'h0000;
  localparam logic [15:0] AUDIO_RATE_RESET = 16'h0000;
  localparam logic [15:0] TONE_RESET = 16'h0000;
  localparam logic [15:0] PLAY_SPEED_RESET = 16'h0001;
  localparam logic [15:0] VOLUME_POWERDOWN = 16'hFFFF;
  localparam logic [15:0] HEADER_WAV_CODE = 16'h7665;
  localparam logic [15:0] END_FILL_PCM = 16'h0000;
  localparam logic [31:0] POSITION_UNKNOWN = 32'hFFFFFFFF;
  localparam logic [31:0] PCM_ENDLESS_LEN = 32'hFFFFFFFF;
  localparam logic [31:0] TAG_RIFF = 32'h52494646;
  localparam logic [31:0] TAG_WAVE = 32'h57415645;
  localparam logic [15:0] FMT_LINEAR_PCM = 16'h0001;
  // timing
  localparam int unsigned REF_CLK_HZ = 20000000;
  localparam int unsigned HOLDOFF_CLOCKS = 22000;
  localparam logic [24:0] REF_HZ_25 = 25'(REF_CLK_HZ);

  typedef enum logic [2:0] {
    DOS_ST_IDLE = 3'b001,
    DOS_ST_HEADER = 3'b010,
    DOS_ST_PCM = 3'b100
  } dos_state_e;

  typedef struct packed {
    logic valid;
    logic [15:0] sample;
  } dos_pcm_s;
endpackage

`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------------
// clock range divider and multiplier decode
// ----------------------------------------------------------------------
module dos_clk_gen
  import dos_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_sync_n,
  input wire logic clock_range_select,
  input wire logic [2:0] pll_multiplier_field,
  output logic xtal_tick,
  output logic pll_on,
  output logic [3:0] mult_half
);
  logic div_phase_reg;

  // multiplier in half steps: 0 -> 1.0x, n -> (n + 3) / 2
  function automatic logic [3:0] mult_code(input logic [2:0] m);
    mult_code = (m == 3'h0) ? 4'h2 : 4'({1'b0, m} + 4'h3);
  endfunction

  // the divide-by-two phase; ticks every cycle when range select is clear
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      div_phase_reg <= 1'b0;
      xtal_tick <= 1'b0;
    end else begin
      div_phase_reg <= clock_range_select ? ~div_phase_reg : 1'b0;
      xtal_tick <= clock_range_select ? div_phase_reg : 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pll_on <= 1'b0;
      mult_half <= 4'h2;
    end else begin
      pll_on <= (pll_multiplier_field != 3'h0);
      mult_half <= mult_code(pll_multiplier_field);
    end
  end
endmodule

`default_nettype wire

//--- dos_top.sv
// decoder operation sequencing: reset hold-off of data request, clock and
// power settings, stream format detection, cancel, play parameters.
// assumes a register master on ref_clk and serial input bytes already
// deserialised on ref_clk; control chip select arrives from a pin.
//
// Operation
// - range select halves incoming clock
// - hardware reset clears all state except the chip select path asynchronously
// - reset stops clocks, grounds crystal output
// - outputs default; serial output follows chip select
// - data request low 22000 clocks after reset
// - multiplier resets to 1.0x; host writes 0x9800
// - clock config zero disables PLL
// - low audio rate slows interrupts, core idles
// - volume 0xFFFF powers down analog drivers
// - no decodable format clears header data
// - idle state watches serial input
// - play speed persists across songs
// - byte rate reports nominal speed rate
// - position reads -1 when unknown
// - endless PCM length stays in PCM mode
// - multiplier field scales core clock

`timescale 1ns/10ps
`default_nettype none

module dos_top
  import dos_pkg::*;
#(
  parameter int unsigned HOLDOFF_CYCLES = HOLDOFF_CLOCKS
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic control_chip_select_n,
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] serial_data_input,
  input wire logic sdi_valid,
  output logic [15:0] reg_rdata,
  output logic data_request,
  output logic crystal_output,
  output logic so_oe_n,
  output logic pll_enable,
  output logic [3:0] core_mult_half,
  output logic analog_drivers_on,
  output logic core_idle,
  output dos_pcm_s pcm_out
);
  // ----------------------------------------------------------------------
  // reset and pin synchronisers
  // ----------------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_sync_n;
  logic cs_meta_reg;
  logic cs_sync_reg;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_n <= rst_meta_reg;
    end
  end

  // chip select path keeps working during reset on purpose
  always_ff @(posedge ref_clk) begin
    cs_meta_reg <= control_chip_select_n;
    cs_sync_reg <= cs_meta_reg;
    so_oe_n <= cs_sync_reg;
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  logic [15:0] mode_reg;
  logic [15:0] tone_reg;
  logic [15:0] clock_config_reg;
  logic [15:0] audio_rate_reg;
  logic [15:0] volume_reg;
  logic [15:0] header_data_0_reg;
  logic [15:0] header_data_1_reg;
  logic [15:0] play_speed_reg;
  logic [15:0] byte_rate_reg;
  logic [31:0] position_ms_reg;
  logic [15:0] rdata_next;
  logic [15:0] status_word;
  logic wr_mode;
  logic soft_reset_req;
  logic abandon;
  logic stream_end;
  logic hdr_ok;
  logic hdr_fail;
  dos_state_e state_reg;

  assign wr_mode = reg_wr && (reg_addr == OFS_MODE);
  assign soft_reset_req = wr_mode && reg_wdata[MODE_SOFT_RESET_BIT];

  // soft reset bit self-clears; cancel is cleared when the stream is dropped
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      mode_reg <= MODE_RESET;
    end else if (wr_mode) begin
      mode_reg <= reg_wdata;
    end else begin
      mode_reg[MODE_SOFT_RESET_BIT] <= 1'b0;
      if (abandon) begin
        mode_reg[MODE_CANCEL_BIT] <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      tone_reg <= TONE_RESET;
      clock_config_reg <= CLOCK_CONFIG_RESET;
      volume_reg <= VOLUME_RESET;
      play_speed_reg <= PLAY_SPEED_RESET;
    end else if (reg_wr) begin
      if (reg_addr == OFS_TONE) begin
        tone_reg <= reg_wdata;
      end
      if (reg_addr == OFS_CLOCK_CONFIG) begin
        clock_config_reg <= reg_wdata;
      end
      if (reg_addr == OFS_VOLUME) begin
        volume_reg <= reg_wdata;
      end
      if (reg_addr == OFS_PLAY_SPEED) begin
        play_speed_reg <= reg_wdata;
      end
    end
  end

  // ----------------------------------------------------------------------
  // clock range and multiplier
  // ----------------------------------------------------------------------
  logic xtal_tick;
  logic pll_on;
  logic [3:0] mult_half;

  dos_clk_gen u_clk_gen (
    .ref_clk(ref_clk),
    .rst_sync_n(rst_sync_n),
    .clock_range_select(mode_reg[MODE_CLOCK_RANGE_BIT]),
    .pll_multiplier_field(clock_config_reg[PLL_MULT_MSB:PLL_MULT_LSB]),
    .xtal_tick(xtal_tick),
    .pll_on(pll_on),
    .mult_half(mult_half)
  );

  // oscillator drive; held at ground while in reset
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      crystal_output <= 1'b0;
      pll_enable <= 1'b0;
      core_mult_half <= 4'h2;
      analog_drivers_on <= 1'b0;
    end else begin
      crystal_output <= ~crystal_output;
      pll_enable <= pll_on;
      core_mult_half <= mult_half;
      analog_drivers_on <= (volume_reg != VOLUME_POWERDOWN);
    end
  end

  // ----------------------------------------------------------------------
  // data request hold-off
  // ----------------------------------------------------------------------
  logic [14:0] holdoff_cnt_reg;
  logic holdoff_done;

  assign holdoff_done = (holdoff_cnt_reg == 15'(HOLDOFF_CYCLES));

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      holdoff_cnt_reg <= 15'h0000;
      data_request <= 1'b0;
    end else begin
      if (soft_reset_req) begin
        holdoff_cnt_reg <= 15'h0000;
      end else if (xtal_tick && !holdoff_done) begin
        holdoff_cnt_reg <= holdoff_cnt_reg + 15'h0001;
      end
      data_request <= holdoff_done && !soft_reset_req;
    end
  end

  // ----------------------------------------------------------------------
  // audio interrupt rate and core idle
  // ----------------------------------------------------------------------
  logic [24:0] rate_acc_reg;
  logic [24:0] rate_sum;
  logic sample_tick;

  assign rate_sum = rate_acc_reg + {9'h000, audio_rate_reg[15:1], 1'b0};
  assign sample_tick = xtal_tick && (rate_sum >= REF_HZ_25);

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rate_acc_reg <= 25'h0000000;
      core_idle <= 1'b1;
    end else begin
      if (xtal_tick) begin
        rate_acc_reg <= sample_tick ? rate_sum - REF_HZ_25 : rate_sum;
      end
      core_idle <= (state_reg == DOS_ST_IDLE) || !sample_tick;
    end
  end

  // ----------------------------------------------------------------------
  // stream format detection
  // ----------------------------------------------------------------------
  logic [31:0] shift_reg;
  logic [31:0] shift_next;
  logic [31:0] field_le;
  logic [5:0] hdr_idx_reg;
  logic [31:0] remain_reg;
  logic endless_reg;
  logic wide_reg;
  logic byte_phase_reg;
  logic [7:0] low_byte_reg;
  logic cancel_req;

  assign shift_next = {shift_reg[23:0], serial_data_input};
  assign field_le = {shift_next[7:0], shift_next[15:8], shift_next[23:16], shift_next[31:24]};
  assign cancel_req = mode_reg[MODE_CANCEL_BIT];
  assign abandon = cancel_req && !wr_mode;
  assign hdr_fail = sdi_valid && (state_reg == DOS_ST_HEADER) &&
                    (((hdr_idx_reg == 6'd11) && (shift_next != TAG_WAVE)) ||
                     ((hdr_idx_reg == 6'd21) && (field_le[31:16] != FMT_LINEAR_PCM)));
  assign hdr_ok = sdi_valid && (state_reg == DOS_ST_HEADER) && (hdr_idx_reg == 6'd43);
  assign stream_end = sdi_valid && (state_reg == DOS_ST_PCM) && !endless_reg &&
                      (remain_reg == 32'h00000001);

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_reg <= DOS_ST_IDLE;
      shift_reg <= 32'h00000000;
      hdr_idx_reg <= 6'h00;
    end else if (soft_reset_req || abandon || hdr_fail || stream_end) begin
      state_reg <= DOS_ST_IDLE;
      shift_reg <= 32'h00000000;
      hdr_idx_reg <= 6'h00;
    end else if (sdi_valid) begin
      shift_reg <= shift_next;
      hdr_idx_reg <= hdr_idx_reg + 6'h01;
      unique case (state_reg)
        DOS_ST_IDLE: begin
          hdr_idx_reg <= 6'h04;
          if (shift_next == TAG_RIFF) begin
            state_reg <= DOS_ST_HEADER;
          end
        end
        DOS_ST_HEADER: begin
          if (hdr_ok) begin
            state_reg <= DOS_ST_PCM;
          end
        end
        DOS_ST_PCM: begin
          hdr_idx_reg <= hdr_idx_reg;
        end
      endcase
    end
  end

  // header fields, rates and remaining length
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      header_data_0_reg <= 16'h0000;
      header_data_1_reg <= 16'h0000;
      audio_rate_reg <= AUDIO_RATE_RESET;
      byte_rate_reg <= 16'h0000;
      position_ms_reg <= POSITION_UNKNOWN;
      remain_reg <= 32'h00000000;
      endless_reg <= 1'b0;
      wide_reg <= 1'b1;
    end else begin
      if (soft_reset_req || abandon || hdr_fail || stream_end) begin
        header_data_0_reg <= 16'h0000;
        header_data_1_reg <= 16'h0000;
      end else if (hdr_ok) begin
        header_data_1_reg <= HEADER_WAV_CODE;
        header_data_0_reg <= byte_rate_reg;
      end
      if (sdi_valid && (state_reg == DOS_ST_HEADER)) begin
        if (hdr_idx_reg == 6'd23) begin
          audio_rate_reg[0] <= (field_le[31:16] == 16'h0002);
        end
        if (hdr_idx_reg == 6'd27) begin
          audio_rate_reg[15:1] <= field_le[15:1];
        end
        if (hdr_idx_reg == 6'd31) begin
          byte_rate_reg <= field_le[15:0];
        end
        if (hdr_idx_reg == 6'd35) begin
          wide_reg <= (field_le[23:16] != 8'h08);
        end
        if (hdr_ok) begin
          remain_reg <= field_le;
          endless_reg <= (field_le == PCM_ENDLESS_LEN);
          position_ms_reg <= POSITION_UNKNOWN;
        end
      end else if (sdi_valid && (state_reg == DOS_ST_PCM) && !endless_reg) begin
        remain_reg <= remain_reg - 32'h00000001;
      end
      if (reg_wr && (reg_addr == OFS_AUDIO_RATE)) begin
        audio_rate_reg <= reg_wdata;
      end
    end
  end

  // ----------------------------------------------------------------------
  // pcm sample output
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pcm_out <= '0;
      byte_phase_reg <= 1'b0;
      low_byte_reg <= 8'h00;
    end else begin
      pcm_out.valid <= 1'b0;
      if (state_reg != DOS_ST_PCM) begin
        byte_phase_reg <= 1'b0;
      end else if (sdi_valid && !abandon) begin
        if (!wide_reg) begin
          pcm_out.valid <= 1'b1;
          pcm_out.sample <= {serial_data_input ^ 8'h80, 8'h00};
        end else if (byte_phase_reg) begin
          pcm_out.valid <= 1'b1;
          pcm_out.sample <= {serial_data_input, low_byte_reg};
        end
        low_byte_reg <= serial_data_input;
        byte_phase_reg <= wide_reg && !byte_phase_reg;
      end
    end
  end

  // ----------------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------------
  always_comb begin
    status_word = 16'h0000;
    status_word[STAT_NO_JUMP_BIT] = (state_reg == DOS_ST_HEADER);
    status_word[STAT_ANALOG_PD_BIT] = (volume_reg == VOLUME_POWERDOWN);
    status_word[STAT_PLL_ON_BIT] = pll_on;
    status_word[STAT_DECODING_BIT] = (state_reg == DOS_ST_PCM);
    status_word[STAT_DATA_REQUEST_BIT] = data_request;
    unique case (reg_addr)
      OFS_MODE: rdata_next = mode_reg;
      OFS_STATUS: rdata_next = status_word;
      OFS_TONE: rdata_next = tone_reg;
      OFS_CLOCK_CONFIG: rdata_next = clock_config_reg;
      OFS_AUDIO_RATE: rdata_next = audio_rate_reg;
      OFS_HEADER_DATA_0: rdata_next = header_data_0_reg;
      OFS_HEADER_DATA_1: rdata_next = header_data_1_reg;
      OFS_VOLUME: rdata_next = volume_reg;
      OFS_PLAY_SPEED: rdata_next = play_speed_reg;
      OFS_BYTE_RATE: rdata_next = byte_rate_reg;
      OFS_POSITION_LO: rdata_next = position_ms_reg[15:0];
      OFS_POSITION_HI: rdata_next = position_ms_reg[31:16];
      OFS_END_FILL: rdata_next = END_FILL_PCM;
      default: rdata_next = 16'h0000;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= reg_rd ? rdata_next : 16'h0000;
    end
  end
endmodule

`default_nettype wire

//--- dos_top_sva.sv
// port checker of dos_top
// assumes binding to dos_top: one clock, rst_n as the reset
`timescale 1ns/10ps
`default_nettype none
module dos_top_sva
  import dos_pkg::*;
#(
  parameter int unsigned HOLDOFF_CYCLES = HOLDOFF_CLOCKS
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic control_chip_select_n,
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] serial_data_input,
  input wire logic sdi_valid,
  input wire logic [15:0] reg_rdata,
  input wire logic data_request,
  input wire logic crystal_output,
  input wire logic so_oe_n,
  input wire logic pll_enable,
  input wire logic [3:0] core_mult_half,
  input wire logic analog_drivers_on,
  input wire logic core_idle,
  input wire dos_pcm_s pcm_out
);
  logic [15:0] low_cnt;
  logic [2:0] up_cnt;
  logic [2:0] mult_w;
  logic vol_off_w, range_w;
  // cycles with data request low
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n || data_request) begin
      low_cnt <= 16'h0000;
    end else if (low_cnt != 16'hFFFF) begin
      low_cnt <= low_cnt + 16'h0001;
    end
  end
  // cycles since reset release, saturating
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      up_cnt <= 3'h0;
    end else if (up_cnt != 3'h7) begin
      up_cnt <= up_cnt + 3'h1;
    end
  end
  // last written multiplier, volume off and range bit
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mult_w <= 3'h0;
      vol_off_w <= 1'b0;
      range_w <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == OFS_CLOCK_CONFIG) begin
        mult_w <= reg_wdata[PLL_MULT_MSB:PLL_MULT_LSB];
      end
      if (reg_addr == OFS_VOLUME) begin
        vol_off_w <= (reg_wdata == VOLUME_POWERDOWN);
      end
      if (reg_addr == OFS_MODE) begin
        range_w <= reg_wdata[MODE_CLOCK_RANGE_BIT];
      end
    end
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  AST_RST_OUT: assert property (disable iff (1'b0) (!rst_n && $past(!rst_n)) |->
    (!crystal_output && !data_request && !analog_drivers_on && core_idle))
    else $error("outputs not at reset levels");
  AST_SO_FOLLOW: assert property (so_oe_n == $past(control_chip_select_n, 3))
    else $error("serial output enable not following chip select");
  AST_XTAL_RUN: assert property (up_cnt == 3'h7 |-> crystal_output != $past(crystal_output))
    else $error("crystal output not toggling");
  AST_DATA_REQUEST_HOLD: assert property ($rose(data_request) |->
    low_cnt >= (range_w ? 2 * HOLDOFF_CYCLES - 4 : HOLDOFF_CYCLES))
    else $error("data request rose before hold-off");
  AST_SOFT_DROP: assert property (reg_wr && reg_addr == OFS_MODE &&
    reg_wdata[MODE_SOFT_RESET_BIT] |=> !data_request [*8])
    else $error("data request high after soft reset");
  AST_PLL_SET: assert property (reg_wr && reg_addr == OFS_CLOCK_CONFIG |-> ##3
    (pll_enable == (mult_w != 3'h0) &&
    core_mult_half == ((mult_w == 3'h0) ? 4'h2 : {1'b0, mult_w} + 4'h3)))
    else $error("multiplier outputs wrong");
  AST_VOL_OFF: assert property (reg_wr && reg_addr == OFS_VOLUME |-> ##2
    analog_drivers_on == !vol_off_w)
    else $error("analog driver state wrong");
  AST_PCM_SRC: assert property (pcm_out.valid |-> $past(sdi_valid))
    else $error("sample without input byte");
  COV_DATA_REQUEST: cover property ($rose(data_request));
  COV_PCM: cover property (pcm_out.valid);
  COV_CANCEL: cover property (reg_wr && reg_addr == OFS_MODE && reg_wdata[MODE_CANCEL_BIT]);
endmodule

bind dos_top dos_top_sva #(.HOLDOFF_CYCLES(HOLDOFF_CYCLES)) i_dos_top_sva (
  .ref_clk(ref_clk), .rst_n(rst_n), .control_chip_select_n(control_chip_select_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .serial_data_input(serial_data_input), .sdi_valid(sdi_valid), .reg_rdata(reg_rdata),
  .data_request(data_request), .crystal_output(crystal_output), .so_oe_n(so_oe_n),
  .pll_enable(pll_enable), .core_mult_half(core_mult_half),
  .analog_drivers_on(analog_drivers_on), .core_idle(core_idle), .pcm_out(pcm_out));
`default_nettype wire

//--- dos_host_model.sv
// host model: stream bytes and chip select
// assumes ref_clk from the bench; bench calls its tasks
`timescale 1ns/10ps
`default_nettype none
module dos_host_model
  import dos_pkg::*;
(
  input wire logic ref_clk,
  output logic [7:0] serial_data_input,
  output logic sdi_valid,
  output logic control_chip_select_n
);
  // endless 16-bit mono header, 8000 Hz
  localparam logic [351:0] WAV_HDR = {TAG_RIFF, PCM_ENDLESS_LEN, TAG_WAVE, 32'h666D7420,
    32'h10000000, 16'h0100, 16'h0100, 32'h401F0000, 32'h803E0000, 16'h0200, 16'h1000,
    32'h64617461, PCM_ENDLESS_LEN};
  initial begin
    serial_data_input = 8'h5A;
    sdi_valid = 1'b0;
    control_chip_select_n = 1'b1;
  end
  task automatic cs_set(input logic v);
    @(posedge ref_clk);
    control_chip_select_n <= v;
  endtask
  task automatic send_byte(input logic [7:0] b);
    @(posedge ref_clk);
    serial_data_input <= b;
    sdi_valid <= 1'b1;
    @(posedge ref_clk);
    sdi_valid <= 1'b0;
    // released lane shows no stale byte
    serial_data_input <= ~b;
  endtask
  task automatic send_hdr(input logic [7:0] fmt, input logic [7:0] bits, input int a,
    input int z);
    logic [351:0] h;
    h = WAV_HDR;
    h[191:184] = fmt;
    h[79:72] = bits;
    for (int i = a; i <= z; i++) begin
      send_byte(h[351 - 8 * i -: 8]);
    end
  endtask
  task automatic send_fill(input int k);
    repeat (k) send_byte(END_FILL_PCM[7:0]);
  endtask
endmodule
`default_nettype wire

//--- dos_tb_top.sv
// self-checking bench of dos_top
// assumes the package, design, host model and checker compiled first
`timescale 1ns/10ps
`default_nettype none
module dos_tb_top;
  import dos_pkg::*;
  localparam int unsigned HOLD = 20;
  logic ref_clk, rst_n, reg_wr, reg_rd, sdi_valid, control_chip_select_n;
  logic data_request, crystal_output, so_oe_n, pll_enable, analog_drivers_on, core_idle;
  logic [4:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, last_pcm;
  logic [3:0] core_mult_half;
  logic [7:0] serial_data_input;
  dos_pcm_s pcm_out;
  int error_cnt = 0;
  int samples_checked = 0;
  int cyc = 0, n;
  dos_top #(.HOLDOFF_CYCLES(HOLD)) i_dos_top (.ref_clk(ref_clk), .rst_n(rst_n),
    .control_chip_select_n(control_chip_select_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .serial_data_input(serial_data_input), .sdi_valid(sdi_valid), .reg_rdata(reg_rdata),
    .data_request(data_request), .crystal_output(crystal_output), .so_oe_n(so_oe_n),
    .pll_enable(pll_enable), .core_mult_half(core_mult_half),
    .analog_drivers_on(analog_drivers_on), .core_idle(core_idle), .pcm_out(pcm_out));
  dos_host_model i_dos_host_model (.ref_clk(ref_clk), .serial_data_input(serial_data_input),
    .sdi_valid(sdi_valid), .control_chip_select_n(control_chip_select_n));
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (pcm_out.valid === 1'b1) begin
      last_pcm <= pcm_out.sample;
    end
    if (cyc == 30000) begin
      error_cnt++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic settle(input int k);
    repeat (k) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  task automatic wait_data_request();
    settle(1);
    n = 0;
    while (data_request !== 1'b1 && n < 500) begin
      @(posedge ref_clk);
      n++;
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] e, input string nm,
    input logic [15:0] m = 16'hFFFF);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    chk(nm, e, reg_rdata & m);
  endtask
  task automatic hw_reset();
    @(posedge ref_clk);
    rst_n <= 1'b0;
    settle(6);
    chk("crystal_output", 16'h0000, {15'h0000, crystal_output});
    chk("analog_drivers_on", 16'h0000, {15'h0000, analog_drivers_on});
    chk("so_oe_n", {15'h0000, control_chip_select_n}, {15'h0000, so_oe_n});
    @(posedge ref_clk);
    rst_n <= 1'b1;
    wait_data_request();
    chk("holdoff", 16'h0001, 16'(n >= HOLD && n < 2 * HOLD));
  endtask
  initial begin
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 5'h00;
    reg_wdata = 16'h0000;
    last_pcm = 16'h0000;
    i_dos_host_model.cs_set(1'b0);
    hw_reset();
    rd(OFS_MODE, MODE_RESET, "mode");
    rd(OFS_PLAY_SPEED, PLAY_SPEED_RESET, "play_speed");
    rd(OFS_POSITION_LO, POSITION_UNKNOWN[15:0], "position_lo");
    rd(OFS_POSITION_HI, POSITION_UNKNOWN[31:16], "position_hi");
    rd(OFS_HEADER_DATA_1, 16'h0000, "header_data_1");
    rd(5'h1F, 16'h0000, "unmapped");
    wr(OFS_TONE, 16'h00F6);
    rd(OFS_TONE, 16'h00F6, "tone");
    chk("core_idle", 16'h0001, {15'h0000, core_idle});
    $display("reset test done");
    for (int k = 0; k < 8; k++) begin
      wr(OFS_CLOCK_CONFIG, {k[2:0], 13'h0000});
      settle(3);
      chk("core_mult_half", (k == 0) ? 16'h0002 : 16'(k + 3), {12'h000, core_mult_half});
      chk("pll_enable", 16'(k != 0), {15'h0000, pll_enable});
    end
    wr(OFS_CLOCK_CONFIG, 16'h9800);
    settle(3);
    chk("core_mult_half", 16'h0007, {12'h000, core_mult_half});
    $display("clock test done");
    i_dos_host_model.send_hdr(8'h01, 8'h10, 0, 3);
    rd(OFS_STATUS, 16'h0001, "no_jump", 16'h0001);
    i_dos_host_model.send_hdr(8'h01, 8'h10, 4, 43);
    rd(OFS_HEADER_DATA_1, HEADER_WAV_CODE, "header_data_1");
    rd(OFS_HEADER_DATA_0, 16'h3E80, "header_data_0");
    i_dos_host_model.send_byte(8'h34);
    i_dos_host_model.send_byte(8'h12);
    settle(2);
    chk("pcm_16", 16'h1234, last_pcm);
    wr(OFS_PLAY_SPEED, 16'h0002);
    rd(OFS_BYTE_RATE, 16'h3E80, "byte_rate");
    wr(OFS_CLOCK_CONFIG, 16'h0000);
    wr(OFS_AUDIO_RATE, 16'h0010);
    wr(OFS_VOLUME, VOLUME_POWERDOWN);
    settle(3);
    chk("core_idle", 16'h0001, {15'h0000, core_idle});
    chk("analog_drivers_on", 16'h0000, {15'h0000, analog_drivers_on});
    wr(OFS_VOLUME, 16'h0000);
    wr(OFS_AUDIO_RATE, 16'h0000);
    wr(OFS_CLOCK_CONFIG, 16'h9800);
    settle(3);
    chk("analog_drivers_on", 16'h0001, {15'h0000, analog_drivers_on});
    $display("stream and power test done");
    rd(OFS_END_FILL, END_FILL_PCM, "end_fill");
    i_dos_host_model.send_fill(2052);
    wr(OFS_MODE, 16'h0008);
    i_dos_host_model.send_fill(32);
    rd(OFS_MODE, 16'h0000, "mode_cancel");
    rd(OFS_HEADER_DATA_0, 16'h0000, "header_data_0");
    rd(OFS_PLAY_SPEED, 16'h0002, "play_speed");
    i_dos_host_model.send_hdr(8'h01, 8'h08, 0, 43);
    i_dos_host_model.send_byte(8'hC0);
    settle(2);
    chk("pcm_8", 16'h4000, last_pcm);
    wr(OFS_MODE, 16'h0008);
    i_dos_host_model.send_hdr(8'h02, 8'h10, 0, 43);
    rd(OFS_HEADER_DATA_1, 16'h0000, "header_data_1_bad");
    $display("cancel and format test done");
    wr(OFS_MODE, 16'h8004);
    wait_data_request();
    chk("range_holdoff", 16'h0001, 16'(n >= 2 * HOLD && n < 3 * HOLD));
    wr(OFS_VOLUME, 16'h2424);
    i_dos_host_model.cs_set(1'b1);
    hw_reset();
    rd(OFS_VOLUME, VOLUME_RESET, "volume");
    rd(OFS_PLAY_SPEED, PLAY_SPEED_RESET, "play_speed");
    $display("range and second reset test done");
    give_verdict();
  end
endmodule
`default_nettype wire
